// File: core/sew_pkg.sv
// Shared constants and carrier types for the serial word EEPROM core.
// Assumes a 25 MHz system clock and an AXI4-Lite register master.

package sew_pkg;

   // ==========================================================
   // Array geometry
   localparam int unsigned WORDS = 256;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned PAGE_WORDS = 4;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned PROG_TIME_NS = 10000000;
   localparam int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned PROG_MIN_CYCLES = WORDS + 4;

   // ==========================================================
   // Serial command layout
   localparam logic [3:0] CMD_LAST_BIT = 4'h9;
   localparam logic [3:0] WORD_LAST_BIT = 4'hf;
   localparam logic [3:0] PRREAD_LAST_BIT = 4'h8;
   localparam logic [1:0] OPC_READ = 2'h2;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_PAGE = 2'h3;
   localparam logic [1:0] OPC_EXT = 2'h0;
   localparam logic [1:0] EXT_WDS = 2'h0;
   localparam logic [1:0] EXT_WALL = 2'h1;
   localparam logic [1:0] EXT_WEN = 2'h3;
   localparam logic [7:0] PRCLEAR_ADDR = 8'hff;
   localparam logic [7:0] PRDS_ADDR = 8'h00;
   localparam logic [7:0] PROT_ADDR_RST = 8'hff;

   // Pending programming operations
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_WORD = 3'h1;
   localparam logic [2:0] OP_WALL = 3'h2;
   localparam logic [2:0] OP_PRW = 3'h3;
   localparam logic [2:0] OP_PRCLR = 3'h4;
   localparam logic [2:0] OP_PRDS = 3'h5;

   // ==========================================================
   // Register map
   localparam int unsigned AXI_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_PTR = 8'h08;
   localparam int unsigned CTRL_INHIBIT_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic awvalid;
      logic [AXI_AW-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [AXI_AW-1:0] araddr;
      logic rready;
   } sew_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sew_axi_rsp_s;

   typedef struct packed {
      logic sel;
      logic sclk;
      logic din;
      logic wen;
      logic pre;
   } sew_ser_in_s;

   // Address lies in the shielded region
   function automatic logic sew_protected(input logic [7:0] addr, input logic [7:0] bound,
                                          input logic cleared);
      return !cleared && (addr >= bound);
   endfunction

endpackage

// File: core/sew_prog_timer.sv
// Self-timed programming cycle counter.
// Assumes a one-cycle start pulse that never arrives while busy.

`timescale 1ns/1ns
`default_nettype none

module sew_prog_timer #(
   parameter int unsigned CYCLES = sew_pkg::PROG_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic start,
   output logic busy
);

   typedef struct packed {
      logic [31:0] cnt;
   } sew_tmr_s;

   sew_tmr_s s_ff;
   sew_tmr_s nxt_s;

   if (CYCLES < 1) begin : g_chk
      $error("Programming cycle count must be at least one");
   end

   // ==========================================================
   // Countdown
   always_comb begin
      nxt_s = s_ff;
      if (start) begin
         nxt_s.cnt = CYCLES;
      end else if (s_ff.cnt != 32'h0) begin
         nxt_s.cnt = s_ff.cnt - 32'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign busy = (s_ff.cnt != 32'h0);

endmodule // sew_prog_timer

`default_nettype wire

// File: core/sew_core.sv
// Serial word EEPROM core: serial command engine, array, AXI4-Lite registers.
// Assumes serial pins already synchronous to clk; sclk is sampled for edges.

`timescale 1ns/1ns
`default_nettype none

module sew_core #(
   parameter int unsigned PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire sew_pkg::sew_axi_req_s axi_req,
   output sew_pkg::sew_axi_rsp_s axi_rsp,
   input wire sew_pkg::sew_ser_in_s ser,
   output logic ser_dout,
   output logic ser_dout_oe
);

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CMD = 5'h02,
      ST_RD = 5'h04,
      ST_WD = 5'h08,
      ST_HOLD = 5'h10
   } sew_st_e;

   typedef struct packed {
      sew_st_e st;
      logic clk_q;
      logic sel_q;
      logic [3:0] cnt;
      logic [9:0] cmd;
      logic [7:0] ptr;
      logic [15:0] word;
      logic dout;
      logic prread;
      logic [2:0] nwords;
      logic [2:0] plim;
      logic [3:0][15:0] page;
      logic we_en;
      logic pr_en;
      logic [7:0] prot_addr;
      logic prot_clr;
      logic lock;
      logic [2:0] pend;
      logic rb_show;
      logic [8:0] pidx;
      logic [8:0] pcnt;
      logic [7:0] paddr;
      logic wall;
      logic inhibit;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sew_core_s;

   if (PROG_CYCLES < sew_pkg::PROG_MIN_CYCLES) begin : g_chk
      $error("Programming cycle too short for a full-array write");
   end

   logic [15:0] mem [0:sew_pkg::WORDS-1];
   sew_core_s s_ff;
   sew_core_s nxt_s;
   logic prog_start;
   logic t_busy;
   logic writing;

   sew_prog_timer #(
      .CYCLES(PROG_CYCLES)
   ) u_timer (
      .clk(clk),
      .arst_n(arst_n),
      .start(prog_start),
      .busy(t_busy)
   );

   assign writing = t_busy && (s_ff.pidx < s_ff.pcnt);

   // Register read decode
   function automatic logic [31:0] reg_value(input logic [7:0] a, input sew_core_s s,
                                             input logic busy);
      case (a)
         sew_pkg::REG_CTRL: reg_value = {31'h0, s.inhibit};
         sew_pkg::REG_STATUS: reg_value = {16'h0, s.prot_addr, 3'h0, s.pr_en, s.prot_clr,
                                           s.lock, s.we_en, busy};
         sew_pkg::REG_PTR: reg_value = {24'h0, s.ptr};
         default: reg_value = 32'h0;
      endcase
   endfunction

   function automatic logic reg_mapped(input logic [7:0] a);
      return (a == sew_pkg::REG_CTRL) || (a == sew_pkg::REG_STATUS) ||
             (a == sew_pkg::REG_PTR);
   endfunction

   // ==========================================================
   // Serial engine and register bus
   always_comb begin
      logic rise;
      logic [9:0] full;
      logic [1:0] opc;
      logic [7:0] adr;
      logic wr_ok;
      logic ok;
      rise = 1'b0;
      full = 10'h0;
      opc = 2'h0;
      adr = 8'h0;
      wr_ok = 1'b0;
      ok = 1'b0;
      nxt_s = s_ff;
      prog_start = 1'b0;
      rise = ser.sclk && !s_ff.clk_q;
      full = {s_ff.cmd[8:0], ser.din};
      opc = full[9:8];
      adr = full[7:0];
      wr_ok = s_ff.we_en && ser.wen;
      nxt_s.clk_q = ser.sclk;
      nxt_s.sel_q = ser.sel;
      if (writing) begin
         nxt_s.pidx = s_ff.pidx + 9'h001;
      end
      if (!ser.sel) begin
         nxt_s.st = ST_IDLE;
         nxt_s.pend = sew_pkg::OP_NONE;
         if (s_ff.sel_q && !t_busy && !s_ff.inhibit) begin
            nxt_s.pidx = 9'h0;
            nxt_s.pcnt = 9'h0;
            case (s_ff.pend)
               sew_pkg::OP_WORD: begin
                  ok = (s_ff.nwords != 3'h0);
                  for (int i = 0; i < 4; i++) begin
                     if (3'(i) < s_ff.nwords && sew_pkg::sew_protected(s_ff.paddr + 8'(i),
                         s_ff.prot_addr, s_ff.prot_clr)) begin
                        ok = 1'b0;
                     end
                  end
                  nxt_s.pcnt = {6'h0, s_ff.nwords};
                  nxt_s.wall = 1'b0;
               end
               sew_pkg::OP_WALL: begin
                  ok = (s_ff.nwords != 3'h0) && s_ff.prot_clr;
                  nxt_s.pcnt = 9'(sew_pkg::WORDS);
                  nxt_s.paddr = 8'h0;
                  nxt_s.wall = 1'b1;
               end
               sew_pkg::OP_PRW: begin
                  ok = !s_ff.lock;
                  nxt_s.prot_addr = s_ff.paddr;
                  nxt_s.prot_clr = 1'b0;
               end
               sew_pkg::OP_PRCLR: begin
                  ok = !s_ff.lock;
                  nxt_s.prot_addr = sew_pkg::PROT_ADDR_RST;
                  nxt_s.prot_clr = 1'b1;
               end
               sew_pkg::OP_PRDS: begin
                  ok = !s_ff.lock;
                  nxt_s.lock = 1'b1;
               end
               default: ok = 1'b0;
            endcase
            if (!ok) begin
               nxt_s.prot_addr = s_ff.prot_addr;
               nxt_s.prot_clr = s_ff.prot_clr;
               nxt_s.lock = s_ff.lock;
               nxt_s.pcnt = 9'h0;
            end
            prog_start = ok;
            nxt_s.rb_show = ok || s_ff.rb_show;
         end
      end else if (rise) begin
         case (s_ff.st)
            ST_IDLE: begin
               if (ser.din && !t_busy) begin
                  nxt_s.st = ST_CMD;
                  nxt_s.cnt = 4'h0;
                  nxt_s.rb_show = 1'b0;
                  nxt_s.prread = 1'b0;
                  nxt_s.nwords = 3'h0;
               end
            end
            ST_CMD: begin
               nxt_s.cmd = full;
               nxt_s.cnt = s_ff.cnt + 4'h1;
               if (s_ff.cnt == sew_pkg::CMD_LAST_BIT) begin
                  nxt_s.cnt = 4'h0;
                  nxt_s.st = ST_HOLD;
                  nxt_s.paddr = adr;
                  if (!ser.pre) begin
                     case (opc)
                        sew_pkg::OPC_READ: begin
                           nxt_s.ptr = adr;
                           nxt_s.word = mem[adr];
                           nxt_s.dout = 1'b0;
                           nxt_s.st = ST_RD;
                        end
                        sew_pkg::OPC_WRITE, sew_pkg::OPC_PAGE: begin
                           if (wr_ok) begin
                              nxt_s.pend = sew_pkg::OP_WORD;
                              nxt_s.plim = (opc == sew_pkg::OPC_PAGE) ? 3'(sew_pkg::PAGE_WORDS)
                                                                      : 3'h1;
                              nxt_s.st = ST_WD;
                           end
                        end
                        default: begin
                           case (adr[7:6])
                              sew_pkg::EXT_WALL: begin
                                 if (wr_ok) begin
                                    nxt_s.pend = sew_pkg::OP_WALL;
                                    nxt_s.plim = 3'h1;
                                    nxt_s.st = ST_WD;
                                 end
                              end
                              sew_pkg::EXT_WEN: nxt_s.we_en = ser.wen || s_ff.we_en;
                              sew_pkg::EXT_WDS: nxt_s.we_en = 1'b0;
                              default: nxt_s.we_en = s_ff.we_en;
                           endcase
                        end
                     endcase
                  end else begin
                     case (opc)
                        sew_pkg::OPC_READ: begin
                           nxt_s.word = {s_ff.prot_addr, s_ff.prot_clr, 7'h00};
                           nxt_s.prread = 1'b1;
                           nxt_s.dout = 1'b0;
                           nxt_s.st = ST_RD;
                        end
                        sew_pkg::OPC_WRITE: begin
                           if (wr_ok && s_ff.pr_en && !s_ff.lock) begin
                              nxt_s.pend = sew_pkg::OP_PRW;
                           end
                        end
                        sew_pkg::OPC_PAGE: begin
                           if (wr_ok && s_ff.pr_en && !s_ff.lock &&
                               adr == sew_pkg::PRCLEAR_ADDR) begin
                              nxt_s.pend = sew_pkg::OP_PRCLR;
                           end
                        end
                        default: begin
                           if (wr_ok && adr[7:6] == sew_pkg::EXT_WEN) begin
                              nxt_s.pr_en = 1'b1;
                           end else if (wr_ok && s_ff.pr_en && !s_ff.lock &&
                                        adr == sew_pkg::PRDS_ADDR) begin
                              nxt_s.pend = sew_pkg::OP_PRDS;
                           end
                        end
                     endcase
                  end
               end
            end
            ST_RD: begin
               nxt_s.dout = s_ff.word[sew_pkg::WORD_LAST_BIT - s_ff.cnt];
               nxt_s.cnt = s_ff.cnt + 4'h1;
               if (s_ff.prread && s_ff.cnt == sew_pkg::PRREAD_LAST_BIT) begin
                  nxt_s.st = ST_HOLD;
               end else if (s_ff.cnt == sew_pkg::WORD_LAST_BIT) begin
                  nxt_s.cnt = 4'h0;
                  nxt_s.ptr = s_ff.ptr + 8'h01;
                  nxt_s.word = mem[s_ff.ptr + 8'h01];
               end
            end
            ST_WD: begin
               nxt_s.word = {s_ff.word[14:0], ser.din};
               nxt_s.cnt = s_ff.cnt + 4'h1;
               if (s_ff.cnt == sew_pkg::WORD_LAST_BIT) begin
                  nxt_s.cnt = 4'h0;
                  if (s_ff.nwords < s_ff.plim) begin
                     nxt_s.page[s_ff.nwords[1:0]] = {s_ff.word[14:0], ser.din};
                     nxt_s.nwords = s_ff.nwords + 3'h1;
                  end
               end
            end
            ST_HOLD: nxt_s.st = ST_HOLD;
            default: nxt_s.st = ST_IDLE;
         endcase
      end

      // AXI4-Lite write channel
      if (axi_req.awvalid && axi_rsp.awready) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
         nxt_s.w_got = 1'b1;
         nxt_s.wdata = axi_req.wdata;
         nxt_s.wstrb = axi_req.wstrb;
      end
      if (s_ff.aw_got && s_ff.w_got) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = sew_pkg::RESP_SLVERR;
         if (s_ff.awaddr == sew_pkg::REG_CTRL) begin
            nxt_s.bresp = sew_pkg::RESP_OKAY;
            if (s_ff.wstrb[0]) begin
               nxt_s.inhibit = s_ff.wdata[sew_pkg::CTRL_INHIBIT_BIT];
            end
         end
      end
      if (s_ff.bvalid && axi_req.bready) begin
         nxt_s.bvalid = 1'b0;
      end

      // AXI4-Lite read channel
      if (axi_req.arvalid && axi_rsp.arready) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata = reg_value(axi_req.araddr, s_ff, t_busy);
         nxt_s.rresp = reg_mapped(axi_req.araddr) ? sew_pkg::RESP_OKAY : sew_pkg::RESP_SLVERR;
      end else if (s_ff.rvalid && axi_req.rready) begin
         nxt_s.rvalid = 1'b0;
      end
   end

   // ==========================================================
   // State registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '0;
         s_ff.st <= ST_IDLE;
         s_ff.prot_addr <= sew_pkg::PROT_ADDR_RST;
         s_ff.prot_clr <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ==========================================================
   // Array programming, one word per clock
   always_ff @(posedge clk) begin
      if (writing) begin
         mem[8'(s_ff.paddr + s_ff.pidx[7:0])] <= s_ff.wall ? s_ff.page[0]
                                                         : s_ff.page[s_ff.pidx[1:0]];
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      axi_rsp.awready = !s_ff.aw_got && !s_ff.bvalid;
      axi_rsp.wready = !s_ff.w_got && !s_ff.bvalid;
      axi_rsp.bvalid = s_ff.bvalid;
      axi_rsp.bresp = s_ff.bresp;
      axi_rsp.arready = !s_ff.rvalid;
      axi_rsp.rvalid = s_ff.rvalid;
      axi_rsp.rdata = s_ff.rdata;
      axi_rsp.rresp = s_ff.rresp;
   end

   assign ser_dout = (s_ff.st == ST_IDLE) ? !t_busy : s_ff.dout;
   assign ser_dout_oe = ser.sel && ((s_ff.st == ST_RD) ||
                        (s_ff.st == ST_HOLD && s_ff.prread) ||
                        (s_ff.st == ST_IDLE && s_ff.rb_show));

endmodule // sew_core

`default_nettype wire

// File: verification/sew_core_properties.sv
// Port assertions for the serial word EEPROM core.
// Assumes one clock domain; bound onto every sew_core instance.
`timescale 1ns/1ns
`default_nettype none

module sew_core_properties #(
   parameter int unsigned PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire sew_pkg::sew_axi_req_s axi_req,
   input wire sew_pkg::sew_axi_rsp_s axi_rsp,
   input wire sew_pkg::sew_ser_in_s ser,
   input wire logic ser_dout,
   input wire logic ser_dout_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // =====
   // Parked busy display length
   int unsigned low_cnt_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt_ff <= 0;
      end else if (ser_dout_oe && !ser_dout && !ser.sclk) begin
         low_cnt_ff <= low_cnt_ff + 1;
      end else begin
         low_cnt_ff <= 0;
      end
   end

   // =====
   // Bus handshakes
   sequence wr_taken;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   sequence rd_taken;
      axi_req.arvalid && axi_rsp.arready;
   endsequence

   wr_answer_a: assert property (wr_taken |-> ##[2:3] axi_rsp.bvalid)
      else $error("write response missing");
   rd_answer_a: assert property (rd_taken |=> axi_rsp.rvalid)
      else $error("read data missing");
   b_done_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
      else $error("write response not retired");
   r_done_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
      else $error("read data not retired");
   b_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
      else $error("write taken while answering");

   // =====
   // Serial pin
   oe_hold_a: assert property (ser_dout_oe && !ser.sclk |=> ser_dout_oe || !ser.sel)
      else $error("output dropped while selected with clock still");
   dout_edge_a: assert property (
      ser_dout_oe && $past(ser_dout_oe) && $fell(ser_dout)
      |-> $past(ser.sclk) && !$past(ser.sclk, 2))
      else $error("output bit moved off a clock rise");
   busy_bound_a: assert property (low_cnt_ff <= PROG_CYCLES + 4)
      else $error("busy shown too long");
   reset_idle_a: assert property ($rose(arst_n) |-> ser_dout && !ser_dout_oe)
      else $error("not idle after reset");
endmodule // sew_core_properties

bind sew_core sew_core_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
   .clk(clk),
   .arst_n(arst_n),
   .axi_req(axi_req),
   .axi_rsp(axi_rsp),
   .ser(ser),
   .ser_dout(ser_dout),
   .ser_dout_oe(ser_dout_oe)
);

`default_nettype wire

// File: verification/sew_host_model.sv
// Host controller model driving select, serial clock and data.
// Assumes clk paces it; each serial clock level lasts several clk cycles.
`timescale 1ns/1ns
`default_nettype none

module sew_host_model (
   input wire logic clk,
   output sew_pkg::sew_ser_in_s ser,
   input wire logic dout
);
   initial ser = '0;

   // =====
   // One bit; serial clock parked low outside frames
   task automatic bit_io(input logic b, output logic q);
      ser.din <= b;
      repeat (3) @(posedge clk);
      ser.sclk <= 1'b1;
      repeat (3) @(posedge clk);
      ser.sclk <= 1'b0;
      repeat (2) @(posedge clk);
      q = dout;
   endtask

   // Start bit, opcode, address; q is the bit after it
   task automatic frame(input logic p, input logic [1:0] op, input logic [7:0] a,
                        output logic q);
      logic [9:0] v;
      v = {op, a};
      ser.pre <= p;
      ser.wen <= 1'b1;
      ser.sel <= 1'b1;
      bit_io(1'b1, q);
      for (int i = 9; i >= 0; i--) begin
         bit_io(v[i], q);
      end
   endtask

   task automatic word(input logic [15:0] d, output logic [15:0] q);
      for (int i = 15; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
   endtask

   task automatic stop();
      ser.sel <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // Select with clock still; cycles from select fall to ready
   task automatic wait_ready(output int n, output logic first);
      ser.sel <= 1'b1;
      repeat (2) @(posedge clk);
      n = 6;
      first = dout;
      while (dout !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      stop();
   endtask
endmodule // sew_host_model

`default_nettype wire

// File: verification/tb_serial_word_eeprom_core.sv
// Self-checking bench for the serial word EEPROM core.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb_serial_word_eeprom_core;
   localparam int unsigned PC = 300;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   sew_pkg::sew_axi_req_s req = '0;
   sew_pkg::sew_axi_rsp_s rsp;
   sew_pkg::sew_ser_in_s ser;
   logic dout;
   logic oe;
   int fail_count = 0;
   int check_count = 0;
   int seed = 15948;
   logic [15:0] mem [256];
   logic [7:0] bound = 8'hff;
   logic clr = 1'b1;

   always #20 clk = ~clk;

   sew_core #(.PROG_CYCLES(PC)) uut (.clk(clk), .arst_n(arst_n), .axi_req(req),
      .axi_rsp(rsp), .ser(ser), .ser_dout(dout), .ser_dout_oe(oe));
   sew_host_model host (.clk(clk), .ser(ser), .dout(dout));

   // =====
   // Expectations and bus cycles
   function automatic logic [31:0] status(input logic pr, input logic lk, input logic we);
      return {16'h0, bound, 3'h0, pr, clr, lk, we, 1'b0};
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      logic ha, hw, hb;
      int n;
      n = 0;
      hb = 1'b0;
      req.awvalid <= w;
      req.wvalid <= w;
      req.bready <= w;
      req.arvalid <= !w;
      req.rready <= !w;
      req.awaddr <= a;
      req.araddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      while (!hb && n < 100) begin
         @(negedge clk);
         ha = w ? rsp.awready : rsp.arready;
         hw = rsp.wready;
         hb = w ? rsp.bvalid : rsp.rvalid;
         q = rsp.rdata;
         r = w ? rsp.bresp : rsp.rresp;
         @(posedge clk);
         if (ha) begin
            req.awvalid <= 1'b0;
            req.arvalid <= 1'b0;
         end
         if (hw) req.wvalid <= 1'b0;
         n++;
      end
      req.bready <= 1'b0;
      req.rready <= 1'b0;
      @(posedge clk);
      `CHK("bus_answer", 1'b1, hb)
   endtask

   task automatic prog_wait();
      int n;
      logic f;
      host.wait_ready(n, f);
      `CHK("busy_low", 1'b0, f)
      `CHK("prog_time", 1'b1, n > PC - 8 && n < PC + 8)
   endtask

   task automatic cmd(input logic p, input logic [1:0] op, input logic [7:0] a,
                      input logic pw);
      logic q;
      host.frame(p, op, a, q);
      host.stop();
      if (pw) prog_wait();
   endtask

   task automatic wr(input logic [1:0] op, input logic [7:0] a, input int n, input logic ok);
      logic q;
      logic [15:0] d, g;
      host.frame(1'b0, op, a, q);
      for (int i = 0; i < n; i++) begin
         d = 16'($random(seed));
         host.word(d, g);
         if (ok && i < sew_pkg::PAGE_WORDS) mem[8'(a + i)] = d;
      end
      host.stop();
      if (ok) prog_wait();
   endtask

   task automatic rd_chk(input logic [7:0] a, input int n);
      logic q;
      logic [15:0] w;
      host.frame(1'b0, 2'h2, a, q);
      `CHK("dummy", 1'b0, q)
      `CHK("read_oe", 1'b1, oe)
      for (int i = 0; i < n; i++) begin
         host.word(16'h0, w);
         `CHK("word", mem[8'(a + i)], w)
      end
      host.stop();
      `CHK("oe_off", 1'b0, oe)
   endtask

   initial begin
      #3_000_000;
      fail_count++;
      print_verdict();
   end

   // =====
   // Main sequence
   initial begin
      logic [31:0] q;
      logic [1:0] r;
      logic b;
      logic [15:0] d, g;
      logic [7:0] a;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      axi(1'b0, sew_pkg::REG_STATUS, 32'h0, q, r);
      `CHK("status_rst", status(0, 0, 0), q)
      axi(1'b1, 8'h0c, 32'h1, q, r);
      `CHK("wr_unmapped", sew_pkg::RESP_SLVERR, r)
      axi(1'b0, 8'h0c, 32'h0, q, r);
      `CHK("rd_unmapped", sew_pkg::RESP_SLVERR, r)
      axi(1'b1, sew_pkg::REG_CTRL, 32'h1, q, r);
      axi(1'b0, sew_pkg::REG_CTRL, 32'h0, q, r);
      `CHK("ctrl", 32'h1, q)
      axi(1'b1, sew_pkg::REG_CTRL, 32'h0, q, r);
      wr(2'h1, 8'h20, 1, 1'b0);
      axi(1'b0, sew_pkg::REG_STATUS, 32'h0, q, r);
      `CHK("status_wds", status(0, 0, 0), q)
      $display("test registers done");
      cmd(1'b0, 2'h0, 8'hc0, 1'b0);
      d = 16'($random(seed));
      host.frame(1'b0, 2'h0, 8'h40, b);
      host.word(d, g);
      host.stop();
      prog_wait();
      for (int i = 0; i < 256; i++) begin
         mem[i] = d;
      end
      rd_chk(8'hff, 3);
      $display("test write all done");
      a = 8'h10 + 8'($random(seed) & 63);
      axi(1'b1, sew_pkg::REG_CTRL, 32'h1, q, r);
      wr(2'h1, a + 8'h1, 1, 1'b0);
      axi(1'b1, sew_pkg::REG_CTRL, 32'h0, q, r);
      wr(2'h1, a, 1, 1'b1);
      rd_chk(a - 8'h1, 3);
      wr(2'h3, 8'hfe, 5, 1'b1);
      rd_chk(8'hfd, 7);
      axi(1'b0, sew_pkg::REG_PTR, 32'h0, q, r);
      `CHK("ptr_wrap", 32'h4, q)
      $display("test word and page done");
      cmd(1'b1, 2'h0, 8'hc0, 1'b0);
      cmd(1'b1, 2'h1, 8'h80, 1'b1);
      bound = 8'h80;
      clr = 1'b0;
      wr(2'h1, 8'h90, 1, 1'b0);
      wr(2'h3, 8'h7e, 4, 1'b0);
      rd_chk(8'h7d, 6);
      wr(2'h3, 8'h7a, 4, 1'b1);
      rd_chk(8'h7a, 4);
      host.frame(1'b1, 2'h2, 8'h00, b);
      `CHK("pr_dummy", 1'b0, b)
      host.word(16'h0, g);
      host.stop();
      `CHK("pr_read", {bound, {8{clr}}}, g)
      cmd(1'b1, 2'h3, 8'hff, 1'b1);
      bound = 8'hff;
      clr = 1'b1;
      axi(1'b0, sew_pkg::REG_STATUS, 32'h0, q, r);
      `CHK("status_clr", status(1, 0, 1), q)
      cmd(1'b1, 2'h1, 8'h80, 1'b1);
      bound = 8'h80;
      clr = 1'b0;
      $display("test protect done");
      cmd(1'b1, 2'h0, 8'h00, 1'b1);
      cmd(1'b1, 2'h3, 8'hff, 1'b0);
      axi(1'b0, sew_pkg::REG_STATUS, 32'h0, q, r);
      `CHK("status_lock", status(1, 1, 1), q)
      cmd(1'b0, 2'h0, 8'h00, 1'b0);
      axi(1'b0, sew_pkg::REG_STATUS, 32'h0, q, r);
      `CHK("status_wdis", status(1, 1, 0), q)
      $display("test lock done");
      print_verdict();
   end
endmodule // tb_serial_word_eeprom_core

`default_nettype wire
